// file: hw/status_bank_pkg.sv
// constants for the motion cpu status register bank
// Functional notes
// - cycle time word refreshed every operation cycle
// - setting error loads offending program number
// - setting error loads erroneous item code
// - initial check records amplifier presence per axis
// - axes 1-16 low word, 17-32 high
// - amplifier gained after power-on sets bit
// - presence bits stay set once set
// - mode switch failures store three error words
`default_nettype none
package status_bank_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// ===========================================
	// register indices
	localparam logic [ADDR_W-1:0] A_CYCLE_TIME  = 4'h0;
	localparam logic [ADDR_W-1:0] A_ERR_PROG    = 4'h1;
	localparam logic [ADDR_W-1:0] A_ERR_ITEM    = 4'h2;
	localparam logic [ADDR_W-1:0] A_AMP_LOW     = 4'h3;
	localparam logic [ADDR_W-1:0] A_AMP_HIGH    = 4'h4;
	localparam logic [ADDR_W-1:0] A_MODE_ERR0   = 4'h5;
	localparam logic [ADDR_W-1:0] A_MODE_ERR1   = 4'h6;
	localparam logic [ADDR_W-1:0] A_MODE_ERR2   = 4'h7;
	localparam logic [ADDR_W-1:0] A_IRQ_STATUS  = 4'h8;
	localparam logic [ADDR_W-1:0] A_IRQ_MASK    = 4'h9;
	localparam logic [DATA_W-1:0] WORD_RESET    = 16'h0000;
	// ===========================================
	// interrupt status bit positions
	localparam int IRQ_SETTING_ERR = 0;
	localparam int IRQ_MODE_ERR    = 1;
	localparam int IRQ_AMP_NEW     = 2;
	localparam int IRQ_BITS        = 3;
endpackage
`default_nettype wire

// file: hw/motion_cpu_status_registers.sv
// motion cpu status register bank with interrupt status and mask
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module motion_cpu_status_registers
	import status_bank_pkg::*;
#(
	parameter int AXES = 32
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              cycle_tick,
	input  wire logic [DATA_W-1:0] cycle_time_us,
	input  wire logic              init_check,
	input  wire logic              servo_program_setting_error_flag,
	input  wire logic [DATA_W-1:0] setting_error_program,
	input  wire logic [DATA_W-1:0] setting_error_item,
	input  wire logic [AXES-1:0]   amp_detect,
	input  wire logic              mode_switch_error,
	input  wire logic [DATA_W-1:0] mode_error_word_0,
	input  wire logic [DATA_W-1:0] mode_error_word_1,
	input  wire logic [DATA_W-1:0] mode_error_word_2,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic [DATA_W-1:0]      reg_rdata,
	output logic                   irq
);
	// ===========================================
	// synchronise amplifier detection pins
	logic [AXES-1:0] amp_meta;
	logic [AXES-1:0] amp_sync;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			amp_meta <= '0;
			amp_sync <= '0;
		end else begin
			amp_meta <= amp_detect;
			amp_sync <= amp_meta;
		end
	end

	// ===========================================
	// status words
	logic [DATA_W-1:0] motion_cycle_time;
	logic [DATA_W-1:0] error_servo_program_number;
	logic [DATA_W-1:0] error_setting_item_code;
	logic [AXES-1:0]   amp_present;
	logic [DATA_W-1:0] mode_switch_error_info_0;
	logic [DATA_W-1:0] mode_switch_error_info_1;
	logic [DATA_W-1:0] mode_switch_error_info_2;
	logic              set_err_d;
	logic              mode_err_d;
	logic [IRQ_BITS-1:0] irq_status;
	logic [IRQ_BITS-1:0] irq_mask;

	logic [DATA_W-1:0] next_motion_cycle_time;
	logic [DATA_W-1:0] next_error_servo_program_number;
	logic [DATA_W-1:0] next_error_setting_item_code;
	logic [AXES-1:0]   next_amp_present;
	logic [DATA_W-1:0] next_mode_switch_error_info_0;
	logic [DATA_W-1:0] next_mode_switch_error_info_1;
	logic [DATA_W-1:0] next_mode_switch_error_info_2;
	logic [IRQ_BITS-1:0] next_irq_status;
	logic [IRQ_BITS-1:0] next_irq_mask;
	logic [DATA_W-1:0] next_reg_rdata;
	logic              set_err_rise;
	logic              mode_err_rise;
	logic              amp_new;

	// ===========================================
	// next-state logic; software writes reach only the irq registers
	always_comb begin
		set_err_rise  = servo_program_setting_error_flag && !set_err_d;
		mode_err_rise = mode_switch_error && !mode_err_d;
		next_motion_cycle_time          = motion_cycle_time;
		next_error_servo_program_number = error_servo_program_number;
		next_error_setting_item_code    = error_setting_item_code;
		next_mode_switch_error_info_0   = mode_switch_error_info_0;
		next_mode_switch_error_info_1   = mode_switch_error_info_1;
		next_mode_switch_error_info_2   = mode_switch_error_info_2;
		if (cycle_tick) begin
			next_motion_cycle_time = cycle_time_us;
		end
		if (set_err_rise) begin
			next_error_servo_program_number = setting_error_program;
			next_error_setting_item_code    = setting_error_item;
		end
		if (mode_err_rise) begin
			next_mode_switch_error_info_0 = mode_error_word_0;
			next_mode_switch_error_info_1 = mode_error_word_1;
			next_mode_switch_error_info_2 = mode_error_word_2;
		end
		// or-in only: a lost amplifier never clears its bit
		next_amp_present = amp_present;
		if (init_check) begin
			next_amp_present = amp_present | amp_sync;
		end else begin
			next_amp_present = amp_present | amp_sync;
		end
		amp_new = |(amp_sync & ~amp_present);
		// write-one-to-clear, but a same-cycle event wins
		next_irq_mask   = irq_mask;
		next_irq_status = irq_status;
		if (reg_write && reg_addr == A_IRQ_STATUS) begin
			next_irq_status = irq_status & ~reg_wdata[IRQ_BITS-1:0];
		end
		if (reg_write && reg_addr == A_IRQ_MASK) begin
			next_irq_mask = reg_wdata[IRQ_BITS-1:0];
		end
		if (set_err_rise) begin
			next_irq_status[IRQ_SETTING_ERR] = 1'b1;
		end
		if (mode_err_rise) begin
			next_irq_status[IRQ_MODE_ERR] = 1'b1;
		end
		if (amp_new) begin
			next_irq_status[IRQ_AMP_NEW] = 1'b1;
		end
		// read mux; writes to status words fall through untouched
		next_reg_rdata = WORD_RESET;
		if (reg_read) begin
			unique case (reg_addr)
				A_CYCLE_TIME: next_reg_rdata = motion_cycle_time;
				A_ERR_PROG:   next_reg_rdata = error_servo_program_number;
				A_ERR_ITEM:   next_reg_rdata = error_setting_item_code;
				A_AMP_LOW:    next_reg_rdata = amp_present[DATA_W-1:0];
				A_AMP_HIGH:   next_reg_rdata = amp_present[2*DATA_W-1:DATA_W];
				A_MODE_ERR0:  next_reg_rdata = mode_switch_error_info_0;
				A_MODE_ERR1:  next_reg_rdata = mode_switch_error_info_1;
				A_MODE_ERR2:  next_reg_rdata = mode_switch_error_info_2;
				A_IRQ_STATUS: next_reg_rdata = {{(DATA_W-IRQ_BITS){1'b0}}, irq_status};
				A_IRQ_MASK:   next_reg_rdata = {{(DATA_W-IRQ_BITS){1'b0}}, irq_mask};
				default:      next_reg_rdata = WORD_RESET;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			motion_cycle_time          <= WORD_RESET;
			error_servo_program_number <= WORD_RESET;
			error_setting_item_code    <= WORD_RESET;
			amp_present                <= '0;
			mode_switch_error_info_0   <= WORD_RESET;
			mode_switch_error_info_1   <= WORD_RESET;
			mode_switch_error_info_2   <= WORD_RESET;
			set_err_d                  <= 1'b0;
			mode_err_d                 <= 1'b0;
			irq_status                 <= '0;
			irq_mask                   <= '0;
			reg_rdata                  <= WORD_RESET;
		end else begin
			motion_cycle_time          <= next_motion_cycle_time;
			error_servo_program_number <= next_error_servo_program_number;
			error_setting_item_code    <= next_error_setting_item_code;
			amp_present                <= next_amp_present;
			mode_switch_error_info_0   <= next_mode_switch_error_info_0;
			mode_switch_error_info_1   <= next_mode_switch_error_info_1;
			mode_switch_error_info_2   <= next_mode_switch_error_info_2;
			set_err_d                  <= servo_program_setting_error_flag;
			mode_err_d                 <= mode_switch_error;
			irq_status                 <= next_irq_status;
			irq_mask                   <= next_irq_mask;
			reg_rdata                  <= next_reg_rdata;
		end
	end

	assign irq = |(irq_status & irq_mask);
endmodule
`default_nettype wire

// file: verification/status_bank_properties.sv
// port-level checks for the motion cpu status register bank
`timescale 1ns/1ps
`default_nettype none
module status_bank_properties
	import status_bank_pkg::*;
#(
	parameter int AXES = 32
) (
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              cycle_tick,
	input wire logic [DATA_W-1:0] cycle_time_us,
	input wire logic              servo_program_setting_error_flag,
	input wire logic [DATA_W-1:0] setting_error_program,
	input wire logic [DATA_W-1:0] setting_error_item,
	input wire logic [AXES-1:0]   amp_detect,
	input wire logic              mode_switch_error,
	input wire logic [DATA_W-1:0] mode_error_word_0,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic              reg_write,
	input wire logic              reg_read,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ====================
	// read answers
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == '0)
		else $error("read data not zero");
	a_unmapped_zero: assert property (reg_read && reg_addr > A_IRQ_MASK |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	a_cycle_fresh: assert property (cycle_tick ##1 reg_read && reg_addr == A_CYCLE_TIME
		|=> reg_rdata == $past(cycle_time_us, 2)) else $error("cycle time stale");
	a_prog_capture: assert property ($rose(servo_program_setting_error_flag) ##1
		reg_read && reg_addr == A_ERR_PROG |=> reg_rdata == $past(setting_error_program, 2))
		else $error("program number not captured");
	a_item_capture: assert property ($rose(servo_program_setting_error_flag) ##1
		reg_read && reg_addr == A_ERR_ITEM |=> reg_rdata == $past(setting_error_item, 2))
		else $error("item code not captured");
	a_mode_capture: assert property ($rose(mode_switch_error) ##1
		reg_read && reg_addr == A_MODE_ERR0 |=> reg_rdata == $past(mode_error_word_0, 2))
		else $error("mode error word not captured");
	a_amp_seen: assert property (amp_detect[0] [*5] ##0 reg_read && reg_addr == A_AMP_LOW
		|=> reg_rdata[0]) else $error("axis 1 presence missing");
	// irq only drops when software clears status or mask
	a_irq_drop: assert property ($fell(irq) |-> $past(reg_write)
		&& ($past(reg_addr) == A_IRQ_STATUS || $past(reg_addr) == A_IRQ_MASK))
		else $error("irq dropped without write");
endmodule
bind motion_cpu_status_registers status_bank_properties #(.AXES(AXES)) u_chk (.*);
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the motion cpu status register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	import status_bank_pkg::*;
	logic              clk = 0, sys_rst = 1, cycle_tick = 0, init_check = 0, irq;
	logic              servo_program_setting_error_flag = 0, mode_switch_error = 0;
	logic              reg_write = 0, reg_read = 0;
	logic [DATA_W-1:0] cycle_time_us = 0, setting_error_program = 0, setting_error_item = 0;
	logic [DATA_W-1:0] mode_error_word_0 = 0, mode_error_word_1 = 0, mode_error_word_2 = 0;
	logic [DATA_W-1:0] reg_wdata = 0, reg_rdata;
	logic [31:0]       amp_detect = 0;
	logic [ADDR_W-1:0] reg_addr = 0;
	int                failures = 0, checked = 0;
	motion_cpu_status_registers #(.AXES(32)) i_dut (.*);
	initial forever #12.5 clk = ~clk;
	// ====================
	// bus and compare helpers
	task cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_write <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 0;
	endtask
	// caller stands just after an edge
	task rq(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		reg_read <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 0;
		#1 cmp(reg_rdata, e);
	endtask
	task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge clk);
		rq(a, e);
	endtask
	task wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ====================
	// scenarios
	task t_cycle(input logic [DATA_W-1:0] v);
		@(posedge clk);
		cycle_tick <= 1;
		cycle_time_us <= v;
		@(posedge clk);
		cycle_tick <= 0;
		rq(A_CYCLE_TIME, v);
		wr(A_CYCLE_TIME, ~v);
		rd(A_CYCLE_TIME, v);
		$display("t_cycle done");
	endtask
	task t_events;
		@(posedge clk);
		servo_program_setting_error_flag <= 1;
		setting_error_program <= 16'h0123;
		setting_error_item <= 16'h0045;
		rd(A_ERR_PROG, 16'h0123);
		rd(A_ERR_ITEM, 16'h0045);
		cmp({15'h0, irq}, 16'h0000);
		@(posedge clk);
		mode_switch_error <= 1;
		mode_error_word_0 <= 16'h0a01;
		mode_error_word_1 <= 16'h0b02;
		mode_error_word_2 <= 16'h0c03;
		rd(A_MODE_ERR0, 16'h0a01);
		rd(A_MODE_ERR1, 16'h0b02);
		rd(A_MODE_ERR2, 16'h0c03);
		wr(A_MODE_ERR2, 16'h0000);
		rd(A_MODE_ERR2, 16'h0c03);
		$display("t_events done");
	endtask
	task t_amp;
		@(posedge clk);
		init_check <= 1;
		amp_detect <= 32'h0001_8001;
		repeat (6) @(posedge clk);
		init_check <= 0;
		rd(A_AMP_LOW, 16'h8001);
		rd(A_AMP_HIGH, 16'h0001);
		@(posedge clk);
		amp_detect <= 32'h8001_0000;
		repeat (6) @(posedge clk);
		rd(A_AMP_LOW, 16'h8001);
		rd(A_AMP_HIGH, 16'h8001);
		$display("t_amp done");
	endtask
	task t_irq;
		rd(A_IRQ_STATUS, 16'h0007);
		wr(A_IRQ_MASK, 16'h0007);
		#1 cmp({15'h0, irq}, 16'h0001);
		wr(A_IRQ_STATUS, 16'h0007);
		#1 cmp({15'h0, irq}, 16'h0000);
		rd(A_IRQ_STATUS, 16'h0000);
		rd(4'hf, 16'h0000);
		$display("t_irq done");
	endtask
	initial begin
		#1000000 failures++;
		wrap_up;
	end
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 0;
		for (int i = 0; i < 16; i++) rd(ADDR_W'(i), 16'h0000);
		t_cycle(16'h03e8);
		t_cycle(16'h01f4);
		t_events;
		t_amp;
		t_irq;
		wrap_up;
	end
endmodule
`default_nettype wire
